/* pkg/tmc_defines.svh */
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TMC_OFS_COUNT_LOW 4'h0
`define TMC_OFS_HIGH_BUF 4'h1
`define TMC_OFS_CTL_ZERO 4'h2
`define TMC_OFS_CTL_ONE 4'h3
`define TMC_OFS_IRQ_STATUS 4'h4
`define TMC_OFS_IRQ_MASK 4'h5

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TMC_IRQ_EVENT_BIT 0
`define TMC_IRQ_MATCH_BIT 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TMC_RST_COUNT_LOW 8'h00
`define TMC_RST_HIGH_BUF 8'hFF
`define TMC_RST_CTL_ZERO 8'h00
`define TMC_RST_CTL_ONE 8'h00
`define TMC_RST_IRQ 8'h00

// ---------------------------------------------------------------
// timing counts
// ---------------------------------------------------------------
`define TMC_INSTR_DIV 2'h3

`endif

/* pkg/tmc_pkg.sv */
`default_nettype none

package tmc_pkg;

    // -----------------------------------------------------------
    // control register layouts
    // -----------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic unused6;
        logic output_level;
        logic width_select_bit;
        logic [3:0] postscale_select;
    } tmc_ctl_zero_s;

    typedef struct packed {
        logic [1:0] unused7;
        logic source_external;
        logic async_enable_bit;
        logic [3:0] prescale_select;
    } tmc_ctl_one_s;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmc_bus_req_s;

    // -----------------------------------------------------------
    // whole block state
    // -----------------------------------------------------------
    typedef struct packed {
        logic [7:0] count_low_byte;
        logic [7:0] count_high;
        logic [7:0] high_byte_buffer;
        logic [7:0] period_buf;
        tmc_ctl_zero_s ctl_zero;
        tmc_ctl_one_s ctl_one;
        logic [14:0] prescale_cnt;
        logic [3:0] postscale_cnt;
        logic match_pulse;
        logic out_toggle;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [1:0] instr_div;
        logic ext_sync1;
        logic ext_sync2;
        logic ext_prev;
        logic sleep_sync1;
        logic sleep_sync2;
        logic ext_pending;
        logic [7:0] rdata;
    } tmc_state_s;

endpackage : tmc_pkg

`default_nettype wire

/* hw/tmc_timer.sv */
// Our own choices: the strobed register port and the register addresses.

`include "tmc_defines.svh"

`default_nettype none

module tmc_timer
    import tmc_pkg::*;
#(
    parameter int PRESCALE_BITS = 15
) (
    input wire logic I_CLK, // system clock
    input wire logic I_RESET_N, // asynchronous reset, active low
    input wire logic [3:0] I_ADDR, // register index
    input wire logic [7:0] I_WDATA, // write data
    input wire logic I_WR, // write strobe
    input wire logic I_RD, // read strobe
    input wire logic I_COUNT_PIN, // external count source pin
    input wire logic I_SLEEP, // device sleep level
    output logic [7:0] O_RDATA, // read data, cycle after strobe
    output logic O_MATCH_PULSE, // one prescaled period per match
    output logic O_TIMER_OUT, // toggles on each postscaled event
    output logic O_IRQ // level interrupt
);

    // ---------------------------------------------------------------
    // elaboration check
    // ---------------------------------------------------------------
    // the 4-bit select reaches 1:32768, so exactly 15 stages are needed
    if (PRESCALE_BITS != 15) begin : g_bad_prescale
        $error("tmc_timer: PRESCALE_BITS must be 15");
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // mask of prescaler bits that must be all ones for a tick
    function automatic logic [14:0] prescale_mask(input logic [3:0] sel);
        logic [15:0] one_hot;
        one_hot = 16'h0001 << sel;
        return one_hot[14:0] - 15'h0001;
    endfunction : prescale_mask

    // register hit for a strobe
    function automatic logic hit(input logic strobe, input logic [3:0] addr, input logic [3:0] ofs);
        return strobe && (addr == ofs);
    endfunction : hit

    tmc_state_s s_q;
    tmc_state_s s_d;
    tmc_bus_req_s req;

    logic wr_low;
    logic wr_high;
    logic wr_ctl0;
    logic wr_ctl1;
    logic wr_stat;
    logic wr_mask;
    logic rd_low;
    logic instr_tick;
    logic ext_edge;
    logic src_edge;
    logic pre_tick;
    logic is_8bit;
    logic match_ev;
    logic post_ev;
    logic clear_scalers;
    logic [15:0] count16;
    logic [14:0] pre_mask;

    // reset image of the whole state; pin stages idle high so no false edge follows reset
    localparam tmc_state_s RST_STATE = '{
        count_low_byte: `TMC_RST_COUNT_LOW,
        count_high: 8'h00,
        high_byte_buffer: `TMC_RST_HIGH_BUF,
        period_buf: `TMC_RST_HIGH_BUF,
        ctl_zero: tmc_ctl_zero_s'(`TMC_RST_CTL_ZERO),
        ctl_one: tmc_ctl_one_s'(`TMC_RST_CTL_ONE),
        prescale_cnt: 15'h0000,
        postscale_cnt: 4'h0,
        match_pulse: 1'b0,
        out_toggle: 1'b0,
        irq_status: `TMC_RST_IRQ,
        irq_mask: `TMC_RST_IRQ,
        instr_div: 2'h0,
        ext_sync1: 1'b1,
        ext_sync2: 1'b1,
        ext_prev: 1'b1,
        sleep_sync1: 1'b0,
        sleep_sync2: 1'b0,
        ext_pending: 1'b0,
        rdata: 8'h00
    };

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    // strobes come from logic on I_CLK, so no synchroniser is needed
    assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign wr_low = hit(req.wr, req.addr, `TMC_OFS_COUNT_LOW);
    assign wr_high = hit(req.wr, req.addr, `TMC_OFS_HIGH_BUF);
    assign wr_ctl0 = hit(req.wr, req.addr, `TMC_OFS_CTL_ZERO);
    assign wr_ctl1 = hit(req.wr, req.addr, `TMC_OFS_CTL_ONE);
    assign wr_stat = hit(req.wr, req.addr, `TMC_OFS_IRQ_STATUS);
    assign wr_mask = hit(req.wr, req.addr, `TMC_OFS_IRQ_MASK);
    assign rd_low = hit(req.rd, req.addr, `TMC_OFS_COUNT_LOW);

    // ---------------------------------------------------------------
    // count source
    // ---------------------------------------------------------------
    // instruction cycle is every fourth system clock, halted in sleep
    assign instr_tick = (s_q.instr_div == `TMC_INSTR_DIV) && !s_q.sleep_sync2;
    // edge of the pin after the two-stage synchroniser
    assign ext_edge = s_q.ext_sync2 && !s_q.ext_prev;
    assign is_8bit = !s_q.ctl_zero.width_select_bit;

    // source edge as the counter sees it; a synchronous pin edge waits
    // for the instruction tick, so in synchronous mode the count can never outrun Fosc/4
    always_comb begin
        if (!s_q.ctl_zero.enable) begin
            src_edge = 1'b0;
        end else if (!s_q.ctl_one.source_external) begin
            src_edge = instr_tick;
        end else if (s_q.ctl_one.async_enable_bit) begin
            src_edge = ext_edge;
        end else begin
            src_edge = instr_tick && (ext_edge || s_q.ext_pending);
        end
    end

    // ---------------------------------------------------------------
    // prescaler and match detection
    // ---------------------------------------------------------------
    // code 0000 gives an empty mask, so every source edge is a tick
    assign pre_mask = prescale_mask(s_q.ctl_one.prescale_select);
    assign pre_tick = src_edge && ((s_q.prescale_cnt & pre_mask) == pre_mask);

    // the real 16-bit count; its high byte is hidden from software
    assign count16 = {s_q.count_high, s_q.count_low_byte};

    // 8-bit compares low byte with the period copy, 16-bit waits for rollover
    always_comb begin
        if (is_8bit) begin
            match_ev = pre_tick && (s_q.count_low_byte == s_q.period_buf);
        end else begin
            match_ev = pre_tick && (count16 == 16'hFFFF);
        end
    end

    // postscaler lets one of every postscale_select+1 matches through
    assign post_ev = match_ev && (s_q.postscale_cnt == s_q.ctl_zero.postscale_select);

    // writes that restart both scaler counters
    assign clear_scalers = wr_low || wr_ctl0 || wr_ctl1;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // pin synchronisers: only the second stage and ext_prev feed any logic
        s_d.ext_sync1 = I_COUNT_PIN;
        s_d.ext_sync2 = s_q.ext_sync1;
        s_d.ext_prev = s_q.ext_sync2;
        s_d.sleep_sync1 = I_SLEEP;
        s_d.sleep_sync2 = s_q.sleep_sync1;

        // instruction cycle divider runs free, even while stopped
        s_d.instr_div = s_q.instr_div + 2'h1;

        // a synchronous pin edge is held until the next instruction tick
        if (!s_q.ctl_zero.enable || instr_tick) begin
            s_d.ext_pending = 1'b0;
        end
        if (s_q.ctl_zero.enable && ext_edge && !instr_tick) begin
            s_d.ext_pending = 1'b1;
        end

        // prescaler counts source edges and restarts on each tick
        if (clear_scalers) begin
            s_d.prescale_cnt = 15'h0000;
        end else if (pre_tick) begin
            s_d.prescale_cnt = 15'h0000;
        end else if (src_edge) begin
            s_d.prescale_cnt = s_q.prescale_cnt + 15'h0001;
        end

        // count on every prescaled tick
        if (pre_tick) begin
            if (is_8bit) begin
                if (s_q.count_low_byte == s_q.period_buf) begin
                    s_d.count_low_byte = 8'h00;
                    s_d.period_buf = s_q.high_byte_buffer;
                end else begin
                    s_d.count_low_byte = s_q.count_low_byte + 8'h01;
                end
            end else begin
                // FFFF wraps to 0000 on its own
                {s_d.count_high, s_d.count_low_byte} = count16 + 16'h0001;
            end
        end

        // match output stands from one prescaled tick to the next
        if (!s_q.ctl_zero.enable) begin
            s_d.match_pulse = 1'b0;
        end else if (pre_tick) begin
            s_d.match_pulse = match_ev;
        end

        // postscaler counts matches
        if (clear_scalers) begin
            s_d.postscale_cnt = 4'h0;
        end else if (post_ev) begin
            s_d.postscale_cnt = 4'h0;
        end else if (match_ev) begin
            s_d.postscale_cnt = s_q.postscale_cnt + 4'h1;
        end

        // output toggles on each postscaled event, a 50% duty square
        if (post_ev) begin
            s_d.out_toggle = !s_q.out_toggle;
        end

        // low byte write: in 16-bit mode the hidden high byte loads with it
        if (wr_low) begin
            s_d.count_low_byte = req.wdata;
            if (is_8bit) begin
                s_d.period_buf = s_q.high_byte_buffer;
            end else begin
                s_d.count_high = s_q.high_byte_buffer;
            end
        end

        // high byte register, period copied at match or low write in 8-bit mode, a buffer in 16-bit mode
        if (wr_high) begin
            s_d.high_byte_buffer = req.wdata;
        end

        // in 16-bit mode a low byte read snapshots the real high byte for a torn-free pair
        if (rd_low && !is_8bit) begin
            s_d.high_byte_buffer = s_q.count_high;
        end

        // control registers; the output level bit is read-only
        if (wr_ctl0) begin
            s_d.ctl_zero.enable = req.wdata[7];
            s_d.ctl_zero.unused6 = 1'b0;
            s_d.ctl_zero.output_level = 1'b0;
            s_d.ctl_zero.width_select_bit = req.wdata[4];
            s_d.ctl_zero.postscale_select = req.wdata[3:0];
        end
        if (wr_ctl1) begin
            s_d.ctl_one.unused7 = 2'h0;
            s_d.ctl_one.source_external = req.wdata[5];
            s_d.ctl_one.async_enable_bit = req.wdata[4];
            s_d.ctl_one.prescale_select = req.wdata[3:0];
        end

        // sticky status, write one to clear; a new event in the same cycle wins
        if (wr_stat) begin
            s_d.irq_status = s_q.irq_status & ~req.wdata;
        end
        if (post_ev) begin
            s_d.irq_status[`TMC_IRQ_EVENT_BIT] = 1'b1;
        end
        if (match_ev) begin
            s_d.irq_status[`TMC_IRQ_MATCH_BIT] = 1'b1;
        end
        if (wr_mask) begin
            s_d.irq_mask = req.wdata;
        end

        // read data stands only in the cycle after the strobe
        s_d.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `TMC_OFS_COUNT_LOW: begin
                    s_d.rdata = s_q.count_low_byte;
                end
                `TMC_OFS_HIGH_BUF: begin
                    s_d.rdata = s_q.high_byte_buffer;
                end
                `TMC_OFS_CTL_ZERO: begin
                    s_d.rdata = {s_q.ctl_zero.enable, 1'b0, s_q.out_toggle,
                        s_q.ctl_zero.width_select_bit, s_q.ctl_zero.postscale_select};
                end
                `TMC_OFS_CTL_ONE: begin
                    s_d.rdata = {2'h0, s_q.ctl_one.source_external,
                        s_q.ctl_one.async_enable_bit, s_q.ctl_one.prescale_select};
                end
                `TMC_OFS_IRQ_STATUS: begin
                    s_d.rdata = s_q.irq_status;
                end
                `TMC_OFS_IRQ_MASK: begin
                    s_d.rdata = s_q.irq_mask;
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // device reset clears count and both scalers, high byte to all ones
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // all data outputs come straight from flip-flops
    assign O_RDATA = s_q.rdata;
    assign O_MATCH_PULSE = s_q.match_pulse;
    assign O_TIMER_OUT = s_q.out_toggle;
    // level interrupt while any unmasked status bit is set
    assign O_IRQ = |(s_q.irq_status & s_q.irq_mask);

    // note: holds because the async path above is not gated by sleep

endmodule : tmc_timer

`default_nettype wire

/* verification/tmc_timer_assertions.sv */
`default_nettype none
module tmc_timer_chk (
    input wire logic I_CLK, // clk
    input wire logic I_RESET_N, // rst
    input wire logic [3:0] I_ADDR, // addr
    input wire logic [7:0] I_WDATA, // wdata
    input wire logic I_WR, // wr
    input wire logic I_RD, // rd
    input wire logic [7:0] O_RDATA, // rdata
    input wire logic O_MATCH_PULSE, // match
    input wire logic O_TIMER_OUT, // out
    input wire logic O_IRQ // irq
);
    logic [2:0] en_q;
    wire logic idle;
    // enable history, so late pipeline effects after a stop are not judged
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) en_q <= 3'h0;
        else en_q <= {en_q[1:0], (I_WR && I_ADDR == 4'h2) ? I_WDATA[7] : en_q[0]};
    end
    assign idle = (en_q == 3'h0);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    stop_match_a: assert property (idle |-> !O_MATCH_PULSE) else $error("match while stopped");
    stop_out_a: assert property (idle |-> $stable(O_TIMER_OUT)) else $error("output moved");
    irq_quiet_a: assert property (idle && !$past(I_WR) |-> !$rose(O_IRQ)) else $error("irq rose");
    reset_irq_a: assert property (!$past(I_RESET_N) |-> !O_IRQ) else $error("irq after reset");
    low_back_a: assert property (idle && I_WR && I_ADDR == 4'h0 ##1 I_RD && I_ADDR == 4'h0
        |=> O_RDATA == $past(I_WDATA, 2)) else $error("low byte readback");
    high_back_a: assert property (I_WR && I_ADDR == 4'h1 ##1 I_RD && I_ADDR == 4'h1
        |=> O_RDATA == $past(I_WDATA, 2)) else $error("high buffer readback");
    ctl_back_a: assert property (I_WR && I_ADDR == 4'h3 ##1 I_RD && I_ADDR == 4'h3
        |=> O_RDATA == ($past(I_WDATA, 2) & 8'h3F)) else $error("control readback");
    low_hold_a: assert property (idle && I_RD && I_ADDR == 4'h0 ##1 I_RD && I_ADDR == 4'h0
        |=> O_RDATA == $past(O_RDATA)) else $error("count moved while stopped");
endmodule : tmc_timer_chk
bind tmc_timer tmc_timer_chk i_chk (.I_CLK, .I_RESET_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
    .O_RDATA, .O_MATCH_PULSE, .O_TIMER_OUT, .O_IRQ);
`default_nettype wire

/* verification/tmc_timer_bench.sv */
`default_nettype none
module tmc_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CLK = 0, I_RESET_N = 0, wr = 0, rd = 0, match_seen = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, got;
    logic pulse, tout, irq;
    int miscompares = 0, checks_done = 0, cycles = 0;
    tmc_timer i_dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .I_COUNT_PIN(1'b0), .I_SLEEP(1'b0), .O_RDATA(rdata),
        .O_MATCH_PULSE(pulse), .O_TIMER_OUT(tout), .O_IRQ(irq));
    initial begin
        forever #2.5 I_CLK = ~I_CLK;
    end
    // hang guard, well above the slowest first match
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one bus cycle; strobes may follow each other with no gap
    task automatic step(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask : step
    task automatic rdb(input logic [3:0] a, output logic [7:0] v);
        step(0, 1, a, 8'h00);
        step(0, 0, a, 8'h00);
        @(negedge I_CLK);
        v = rdata;
    endtask : rdb
    initial begin
        repeat (3) @(posedge I_CLK);
        I_RESET_N <= 1;
        rdb(4'h0, got); check(got, 8'h00);
        rdb(4'h1, got); check(got, 8'hFF);
        step(1, 0, 4'h1, 8'h34); rdb(4'h1, got); check(got, 8'h34);
        step(1, 0, 4'h0, 8'h12); step(0, 1, 4'h0, 8'h00); rdb(4'h0, got); check(got, 8'h12);
        step(1, 0, 4'h3, 8'h05); rdb(4'h3, got); check(got, 8'h05);
        // 16-bit: high byte moves only through the buffer
        step(1, 0, 4'h2, 8'h10); step(1, 0, 4'h1, 8'hAB); step(1, 0, 4'h0, 8'hCD);
        step(1, 0, 4'h1, 8'h00); rdb(4'h0, got); check(got, 8'hCD);
        rdb(4'h1, got); check(got, 8'hAB);
        // 8-bit, first period 34 from the earlier low write (03 loads at that match), no scaling, timer mode
        step(1, 0, 4'h3, 8'h00); step(1, 0, 4'h1, 8'h03); step(1, 0, 4'h0, 8'h00);
        step(1, 0, 4'h5, 8'hFF); step(1, 0, 4'h2, 8'h80); step(0, 0, 4'h0, 8'h00);
        for (int i = 0; i < 5000 && !match_seen; i++) begin
            @(negedge I_CLK);
            match_seen = pulse;
        end
        check({7'h00, match_seen}, 8'h01);
        step(1, 0, 4'h2, 8'h00); rdb(4'h4, got); check(got & 8'h01, 8'h01);
        check({7'h00, irq}, 8'h01);
        step(1, 0, 4'h4, 8'hFF); rdb(4'h4, got); check(got, 8'h00);
        check({7'h00, irq}, 8'h00);
        close_out();
    end
endmodule : tmc_timer_bench
`default_nettype wire
